// File: hw/lad_pkg.sv
// How it works
// [R1] Frame-loss declares after N windows out of sync
// [R2] SLC-96: under 77 bit-2 ones per window
// [R3] ESF: over 7 FF00 data-link patterns per window
// [R4] DM: under 4 CH24 bit-6 ones per window
// [R5] J1 SF: under 4 frame-12 F-bit zeros
// [R6] Other data-link format: under 3 zeros
// [R7] All-ones: under 61 zeros, N windows, any sync
// [R8] All-ones clears after M good windows
// [R9] Any alarm change sets its pending flag
// [R10] Pending flag clears only on written one
// [R11] Interrupt low while pending and allowed
// [R12] Frame-loss clears after N in-sync windows
// [R13] Remote clears after N good windows; restarts
package lad_pkg;

    // Window timing
    localparam int          CLK_HZ         = 40_000_000;
    localparam int          WINDOW_MS      = 40;
    localparam int          WINDOW_CYCLES  = CLK_HZ / 1000 * WINDOW_MS;
    localparam int          WIN_W          = 21;

    // Register indices; byte address is four times the index
    localparam int          ADDR_W         = 12;
    localparam logic [7:0]  IDX_FORMAT     = 8'hB8;
    localparam logic [7:0]  IDX_STATE      = 8'hB9;
    localparam logic [7:0]  IDX_IRQ_EN     = 8'hBA;
    localparam logic [7:0]  IDX_IRQ_FLAGS  = 8'hBB;
    localparam logic [7:0]  IDX_FL_DECL    = 8'hBC;
    localparam logic [7:0]  IDX_FL_CLR     = 8'hBD;
    localparam logic [7:0]  IDX_RM_DECL    = 8'hBE;
    localparam logic [7:0]  IDX_RM_CLR     = 8'hBF;
    localparam logic [7:0]  IDX_AO_DECL    = 8'hC0;
    localparam logic [7:0]  IDX_AO_CLR     = 8'hC1;

    // Alarm bit positions in state, enable and flag registers
    localparam int          BIT_FL         = 0;
    localparam int          BIT_RM         = 1;
    localparam int          BIT_AO         = 2;

    // Reset values
    localparam logic [7:0]  THR_RESET      = 8'h01;
    localparam logic [2:0]  FMT_RESET      = 3'h1;

    // Per-window criteria
    localparam logic [7:0]  SLC_ONES_MIN   = 8'h4D;
    localparam logic [7:0]  ESF_PAT_MAX    = 8'h07;
    localparam logic [15:0] ESF_PATTERN    = 16'hFF00;
    localparam logic [7:0]  DM_ONES_MIN    = 8'h04;
    localparam logic [7:0]  J1_ZEROS_MIN   = 8'h04;
    localparam logic [7:0]  DL_ZEROS_MIN   = 8'h03;
    localparam logic [7:0]  AO_ZEROS_MIN   = 8'h3D;

    // AXI responses
    localparam logic [1:0]  RESP_OKAY      = 2'h0;
    localparam logic [1:0]  RESP_SLVERR    = 2'h2;

    // Framing formats held in the format register
    typedef enum logic [2:0] {
        FMT_SF       = 3'h0,
        FMT_ESF      = 3'h1,
        FMT_DM       = 3'h2,
        FMT_SLC96    = 3'h3,
        FMT_J1SF     = 3'h4,
        FMT_DL_OTHER = 3'h5
    } lad_fmt_type;

endpackage

// File: hw/lad_line_alarm_detector.sv
// Implementation choice: the AXI4-Lite slave port.
`timescale 1ns/10ps
module lad_line_alarm_detector
    import lad_pkg::*;
#(
    parameter int WINDOW_LEN = WINDOW_CYCLES
) (
    // Clock, reset, enable
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic              ce,
    // Framer status and received stream
    input  wire logic              in_sync,
    input  wire logic              rx_bit,
    input  wire logic              rx_bit_en,
    input  wire logic              slc_bit2,
    input  wire logic              datalink_bits,
    input  wire logic              dm_y_bit,
    input  wire logic              j1_fbit12,
    // AXI4-Lite write address and data
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    // AXI4-Lite read
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    // Alarm levels and interrupt
    output logic                   frame_loss_alarm_flag,
    output logic                   remote_alarm_flag,
    output logic                   all_ones_alarm_flag,
    output logic                   irq_n
);

    typedef struct packed {
        // Window position and per-window tallies
        logic [WIN_W-1:0]  win_cnt;
        logic [7:0]        cnt_slc;
        logic [7:0]        cnt_pat;
        logic [7:0]        cnt_dm;
        logic [7:0]        cnt_j1;
        logic [7:0]        cnt_dlz;
        logic [7:0]        cnt_zero;
        logic [15:0]       dl_shift;
        logic              oos_seen;
        logic              sync_seen;

        // Alarm levels, software flags and thresholds
        logic [2:0]        alarm;
        logic [2:0]        flags;
        logic [2:0]        enable;
        logic [5:0][7:0]   thr;
        logic [2:0][7:0]   persist;
        logic [2:0]        fmt;

        // Register bus channels
        logic              aw_full;
        logic [ADDR_W-1:0] aw_addr;
        logic              w_full;
        logic [7:0]        w_data;
        logic              w_lane0;
        logic              awready;
        logic              wready;
        logic              bvalid;
        logic [1:0]        bresp;
        logic              arready;
        logic              rvalid;
        logic [31:0]       rdata;
        logic [1:0]        rresp;

        // Registered interrupt pin
        logic              irq_n;
    } lad_state_type;

    lad_state_type s_r;
    lad_state_type s_nxt;

    // Saturating tally step
    function automatic logic [7:0] sat_inc(input logic [7:0] v,
                                           input logic       e);
        sat_inc = (e && v != 8'hFF) ? v + 8'h01 : v;
    endfunction

    // Register index match at a byte address
    function automatic logic idx_hit(input logic [ADDR_W-1:0] a,
                                     input logic [7:0]        idx);
        idx_hit = (a[1:0] == 2'h0) && (a[ADDR_W-1:2] == 10'(idx));
    endfunction

    // Next-state logic
    always_comb begin
        logic [7:0]  t_slc;
        logic [7:0]  t_pat;
        logic [7:0]  t_dm;
        logic [7:0]  t_j1;
        logic [7:0]  t_dlz;
        logic [7:0]  t_zero;
        logic [15:0] shift_in;
        logic        dl_en;
        logic        oos;
        logic        syn;
        logic        win_end;
        logic [2:0]  decl;
        logic [2:0]  clr;
        logic [2:0]  ack;
        logic [8:0]  step;
        logic        w_ok;
        logic [7:0]  rval;
        logic        r_ok;

        // Defaults so every path assigns every temporary
        t_slc    = 8'h00;
        t_pat    = 8'h00;
        t_dm     = 8'h00;
        t_j1     = 8'h00;
        t_dlz    = 8'h00;
        t_zero   = 8'h00;
        shift_in = 16'h0000;
        dl_en    = 1'b0;
        oos      = 1'b0;
        syn      = 1'b0;
        win_end  = 1'b0;
        decl     = 3'h0;
        clr      = 3'h0;
        ack      = 3'h0;
        step     = 9'h000;
        w_ok     = 1'b0;
        rval     = 8'h00;
        r_ok     = 1'b0;

        // State holds unless a branch below moves it
        s_nxt    = s_r;

        // Per-window tallies on the qualified bit positions
        dl_en    = rx_bit_en && datalink_bits;
        shift_in = {s_r.dl_shift[14:0], rx_bit};
        t_slc    = sat_inc(s_r.cnt_slc, rx_bit_en && slc_bit2 && rx_bit);
        t_pat    = sat_inc(s_r.cnt_pat,
                           dl_en && shift_in == ESF_PATTERN); // see [R3]
        t_dm     = sat_inc(s_r.cnt_dm, rx_bit_en && dm_y_bit && rx_bit);
        t_j1     = sat_inc(s_r.cnt_j1, rx_bit_en && j1_fbit12 && !rx_bit);
        t_dlz    = sat_inc(s_r.cnt_dlz, dl_en && !rx_bit);
        t_zero   = sat_inc(s_r.cnt_zero, rx_bit_en && !rx_bit); // see [R7]

        // One cycle of the other sync state spoils a verdict
        oos      = s_r.oos_seen || !in_sync;
        syn      = s_r.sync_seen || in_sync;
        if (dl_en) begin
            s_nxt.dl_shift = shift_in;
        end

        // Fixed 40 ms window; tallies restart at each boundary
        win_end = (s_r.win_cnt == WIN_W'(WINDOW_LEN - 1));
        if (win_end) begin
            s_nxt.win_cnt   = '0;
            s_nxt.cnt_slc   = 8'h00;
            s_nxt.cnt_pat   = 8'h00;
            s_nxt.cnt_dm    = 8'h00;
            s_nxt.cnt_j1    = 8'h00;
            s_nxt.cnt_dlz   = 8'h00;
            s_nxt.cnt_zero  = 8'h00;
            s_nxt.oos_seen  = 1'b0;
            s_nxt.sync_seen = 1'b0;
        end else begin
            s_nxt.win_cnt   = s_r.win_cnt + WIN_W'(1);
            s_nxt.cnt_slc   = t_slc;
            s_nxt.cnt_pat   = t_pat;
            s_nxt.cnt_dm    = t_dm;
            s_nxt.cnt_j1    = t_j1;
            s_nxt.cnt_dlz   = t_dlz;
            s_nxt.cnt_zero  = t_zero;
            s_nxt.oos_seen  = oos;
            s_nxt.sync_seen = syn;
        end

        // Frame-loss window verdicts
        decl[BIT_FL] = !syn;                                 // see [R1]
        clr[BIT_FL]  = !oos;                                 // see [R12]

        // Remote window verdicts by active format
        unique case (s_r.fmt)
            FMT_SLC96: begin
                decl[BIT_RM] = t_slc < SLC_ONES_MIN;          // see [R2]
            end
            FMT_ESF: begin
                decl[BIT_RM] = t_pat > ESF_PAT_MAX;           // see [R3]
            end
            FMT_DM: begin
                decl[BIT_RM] = t_dm < DM_ONES_MIN;            // see [R4]
            end
            FMT_J1SF: begin
                decl[BIT_RM] = t_j1 < J1_ZEROS_MIN;           // see [R5]
            end
            FMT_DL_OTHER: begin
                decl[BIT_RM] = t_dlz < DL_ZEROS_MIN;          // see [R6]
            end
            FMT_SF: begin
                decl[BIT_RM] = 1'b0;
            end
            default: begin
                decl[BIT_RM] = 1'b0;
            end
        endcase
        clr[BIT_RM] = !decl[BIT_RM];                          // see [R13]

        // All-ones window verdicts, independent of sync
        decl[BIT_AO] = t_zero < AO_ZEROS_MIN;                 // see [R7]
        clr[BIT_AO]  = !decl[BIT_AO];                         // see [R8]

        // Persistence over consecutive windows per alarm
        // A threshold of zero acts as one window
        if (win_end) begin
            for (int i = 0; i < 3; i++) begin
                step = {1'b0, s_r.persist[i]} + 9'h001;
                if (!s_r.alarm[i]) begin
                    if (decl[i]) begin
                        if (step >= {1'b0, s_r.thr[2*i]}) begin
                            s_nxt.alarm[i]   = 1'b1;          // see [R1]
                            s_nxt.persist[i] = 8'h00;
                        end else begin
                            s_nxt.persist[i] = step[7:0];
                        end
                    end else begin
                        s_nxt.persist[i] = 8'h00;             // see [R13]
                    end
                end else begin
                    if (clr[i]) begin
                        if (step >= {1'b0, s_r.thr[2*i+1]}) begin
                            s_nxt.alarm[i]   = 1'b0;          // see [R8]
                            s_nxt.persist[i] = 8'h00;
                        end else begin
                            s_nxt.persist[i] = step[7:0];
                        end
                    end else begin
                        s_nxt.persist[i] = 8'h00;             // see [R12]
                    end
                end
            end
        end

        // Write address and data capture, in either order
        if (s_r.awready && s_axi_awvalid) begin
            s_nxt.aw_full = 1'b1;
            s_nxt.aw_addr = s_axi_awaddr;
        end
        if (s_r.wready && s_axi_wvalid) begin
            s_nxt.w_full  = 1'b1;
            s_nxt.w_data  = s_axi_wdata[7:0];
            s_nxt.w_lane0 = s_axi_wstrb[0];
        end

        // Register write once both halves are held
        if (s_r.aw_full && s_r.w_full && !s_r.bvalid) begin
            w_ok = idx_hit(s_r.aw_addr, IDX_FORMAT)
                || idx_hit(s_r.aw_addr, IDX_STATE)
                || idx_hit(s_r.aw_addr, IDX_IRQ_EN)
                || idx_hit(s_r.aw_addr, IDX_IRQ_FLAGS);
            if (s_r.w_lane0) begin
                if (idx_hit(s_r.aw_addr, IDX_FORMAT)) begin
                    s_nxt.fmt = s_r.w_data[2:0];
                end
                if (idx_hit(s_r.aw_addr, IDX_IRQ_EN)) begin
                    s_nxt.enable = s_r.w_data[2:0];
                end
                if (idx_hit(s_r.aw_addr, IDX_IRQ_FLAGS)) begin
                    ack = s_r.w_data[2:0];                    // see [R10]
                end
            end
            for (int k = 0; k < 6; k++) begin
                if (idx_hit(s_r.aw_addr, 8'(IDX_FL_DECL + 8'(k)))) begin
                    w_ok = 1'b1;
                    if (s_r.w_lane0) begin
                        s_nxt.thr[k] = s_r.w_data;
                    end
                end
            end
            s_nxt.aw_full = 1'b0;
            s_nxt.w_full  = 1'b0;
            s_nxt.bvalid  = 1'b1;
            s_nxt.bresp   = w_ok ? RESP_OKAY : RESP_SLVERR;
        end

        // Response leaves once the master takes it
        if (s_r.bvalid && s_axi_bready) begin
            s_nxt.bvalid = 1'b0;
        end

        // Ready low while a half is held or an answer waits
        s_nxt.awready = !s_nxt.aw_full && !s_nxt.bvalid;
        s_nxt.wready  = !s_nxt.w_full && !s_nxt.bvalid;

        // Pending flags: a change in the same cycle beats the clear
        s_nxt.flags = (s_r.flags & ~ack)
                    | (s_nxt.alarm ^ s_r.alarm);              // see [R9]

        // Read channel
        if (s_r.arready && s_axi_arvalid) begin
            r_ok = 1'b1;
            if (idx_hit(s_axi_araddr, IDX_FORMAT)) begin
                rval = {5'h00, s_r.fmt};
            end else if (idx_hit(s_axi_araddr, IDX_STATE)) begin
                rval = {5'h00, s_r.alarm};
            end else if (idx_hit(s_axi_araddr, IDX_IRQ_EN)) begin
                rval = {5'h00, s_r.enable};
            end else if (idx_hit(s_axi_araddr, IDX_IRQ_FLAGS)) begin
                rval = {5'h00, s_r.flags};
            end else begin
                r_ok = 1'b0;
                for (int k = 0; k < 6; k++) begin
                    if (idx_hit(s_axi_araddr,
                                8'(IDX_FL_DECL + 8'(k)))) begin
                        r_ok = 1'b1;
                        rval = s_r.thr[k];
                    end
                end
            end
            s_nxt.arready = 1'b0;
            s_nxt.rvalid  = 1'b1;
            s_nxt.rdata   = {24'h000000, rval};
            s_nxt.rresp   = r_ok ? RESP_OKAY : RESP_SLVERR;
        end

        // Next address only once the data has gone
        if (s_r.rvalid && s_axi_rready) begin
            s_nxt.rvalid  = 1'b0;
            s_nxt.arready = 1'b1;
        end

        // Interrupt pin, active low
        s_nxt.irq_n = !(|(s_nxt.flags & s_nxt.enable));      // see [R11]
    end

    // State register with clock enable and synchronous reset
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_r         <= '0;
            s_r.thr     <= {6{THR_RESET}};
            s_r.fmt     <= FMT_RESET;
            s_r.awready <= 1'b1;
            s_r.wready  <= 1'b1;
            s_r.arready <= 1'b1;
            s_r.irq_n   <= 1'b1;
        end else if (ce) begin
            s_r <= s_nxt;
        end
    end

    // Outputs straight from the state register
    assign s_axi_awready         = s_r.awready;
    assign s_axi_wready          = s_r.wready;
    assign s_axi_bresp           = s_r.bresp;
    assign s_axi_bvalid          = s_r.bvalid;
    assign s_axi_arready         = s_r.arready;
    assign s_axi_rdata           = s_r.rdata;
    assign s_axi_rresp           = s_r.rresp;
    assign s_axi_rvalid          = s_r.rvalid;

    // Alarm levels and interrupt pin
    assign frame_loss_alarm_flag = s_r.alarm[BIT_FL];
    assign remote_alarm_flag     = s_r.alarm[BIT_RM];
    assign all_ones_alarm_flag   = s_r.alarm[BIT_AO];
    assign irq_n                 = s_r.irq_n;

endmodule

// File: verif/lad_line_model.sv
`timescale 1ns/10ps
module lad_line_model (
    // Clock and reset
    input  wire logic       aclk,
    input  wire logic       aresetn,
    // Scenario controls
    input  wire logic [1:0] mode,
    input  wire logic       sync_ok,
    // Framer status and bit stream
    output logic            in_sync,
    output logic            rx_bit,
    output logic            rx_bit_en,
    output logic            slc_bit2,
    output logic            datalink_bits,
    output logic            dm_y_bit,
    output logic            j1_fbit12
);
    logic [3:0] ph_r;

    // Bit phase within one 16-bit word
    always_ff @(posedge aclk) begin
        if (!aresetn)
            ph_r <= 4'h0;
        else
            ph_r <= ph_r + 4'h1;
    end

    // One bit every cycle, counted by every format's tally
    assign rx_bit_en     = 1'b1;
    assign datalink_bits = 1'b1;
    assign slc_bit2      = 1'b1;
    assign dm_y_bit      = 1'b1;
    assign j1_fbit12     = 1'b1;
    assign in_sync       = sync_ok;
    // Mode 0 zeros, 1 all ones, 2 repeating FF00 sent MSB first
    assign rx_bit = (mode == 2'h2) ? ~ph_r[3] : (mode == 2'h1);
endmodule

// File: verif/lad_chk.sv
`timescale 1ns/10ps
module lad_chk
    import lad_pkg::*;
#(
    parameter int WINDOW_LEN = WINDOW_CYCLES
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    // Line side
    input wire logic in_sync,
    input wire logic frame_loss_alarm_flag,
    input wire logic remote_alarm_flag,
    input wire logic all_ones_alarm_flag,
    // Bus handshakes
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    logic [WIN_W-1:0] win_r;

    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // Window phase, zero just after a window ends
    always_ff @(posedge aclk) begin
        if (!aresetn)
            win_r <= '0;
        else if (ce)
            win_r <= (win_r == WIN_W'(WINDOW_LEN - 1)) ? '0 : win_r + 1'b1;
    end

    a_win_edge: assert property (
        $changed({all_ones_alarm_flag, remote_alarm_flag,
        frame_loss_alarm_flag}) |-> win_r == '0)
        else $error("alarm moved inside a window");
    a_fl_rise: assert property (
        $rose(frame_loss_alarm_flag) |-> !$past(in_sync))
        else $error("frame loss raised while in sync");
    a_fl_fall: assert property (
        $fell(frame_loss_alarm_flag) |-> $past(in_sync))
        else $error("frame loss cleared while out of sync");
    a_b_latency: assert property (ce && s_axi_awvalid && s_axi_awready
        && s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid)
        else $error("write response late");
    a_r_latency: assert property (
        ce && s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    a_b_hold: assert property (
        s_axi_bvalid && !(s_axi_bready && ce) |=> s_axi_bvalid)
        else $error("write response dropped");
    a_r_hold: assert property (
        s_axi_rvalid && !(s_axi_rready && ce) |=> s_axi_rvalid)
        else $error("read data dropped");
    a_aw_block: assert property (
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write accepted with response pending");

    c_fl_rise: cover property ($rose(frame_loss_alarm_flag));
    c_rm_rise: cover property ($rose(remote_alarm_flag));
    c_ao_rise: cover property ($rose(all_ones_alarm_flag));
endmodule

bind lad_line_alarm_detector lad_chk #(.WINDOW_LEN(WINDOW_LEN)) chk_u (
    .aclk(aclk), .aresetn(aresetn), .ce(ce), .in_sync(in_sync),
    .frame_loss_alarm_flag(frame_loss_alarm_flag),
    .remote_alarm_flag(remote_alarm_flag),
    .all_ones_alarm_flag(all_ones_alarm_flag),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

// File: verif/lad_line_alarm_detector_tb.sv
`timescale 1ns/10ps
module lad_line_alarm_detector_tb
    import lad_pkg::*;
;
    localparam int W = 200;
    logic        aclk, aresetn, ce, sync_ok, in_sync, rx_bit, rx_en;
    logic        slc, dl, dmy, j1, fl, rm, ao, irq_n;
    logic        awv, awr, wv, wr, bv, bb, arv, arr, rv, rb;
    logic [11:0] awa, ara;
    logic [31:0] wd, rdat;
    logic [3:0]  ws;
    logic [1:0]  mode, br, rr;
    logic [2:0]  al;
    int          bad_count, compares, cyc;

    assign al = {ao, rm, fl};

    lad_line_model line_u (.aclk(aclk), .aresetn(aresetn), .mode(mode),
        .sync_ok(sync_ok), .in_sync(in_sync), .rx_bit(rx_bit),
        .rx_bit_en(rx_en), .slc_bit2(slc), .datalink_bits(dl),
        .dm_y_bit(dmy), .j1_fbit12(j1));

    lad_line_alarm_detector #(.WINDOW_LEN(W)) dut_u (.aclk(aclk),
        .aresetn(aresetn), .ce(ce), .in_sync(in_sync), .rx_bit(rx_bit),
        .rx_bit_en(rx_en), .slc_bit2(slc), .datalink_bits(dl),
        .dm_y_bit(dmy), .j1_fbit12(j1), .s_axi_awaddr(awa),
        .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
        .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wr),
        .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bb),
        .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
        .s_axi_rdata(rdat), .s_axi_rresp(rr), .s_axi_rvalid(rv),
        .s_axi_rready(rb), .frame_loss_alarm_flag(fl),
        .remote_alarm_flag(rm), .all_ones_alarm_flag(ao), .irq_n(irq_n));

    task automatic print_verdict;
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, g);
        compares++;
        if (e !== g) begin
            bad_count++;
            $display("[ERR] %s exp %h got %h", nm, e, g);
        end
    endtask

    // Bounded bus wait
    task automatic guard(inout int n);
        n++;
        if (n > 100) begin
            bad_count++;
            $display("[ERR] bus handshake exp 1 got 0");
            print_verdict;
        end
    endtask

    task automatic wr_reg(input logic [7:0] i, input logic [31:0] d);
        logic a, w;
        int   n;
        a = 1'b0;
        w = 1'b0;
        n = 0;
        awa <= {2'h0, i, 2'h0};
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        while (!(a && w)) begin
            guard(n);
            @(negedge aclk);
            a = a || awr;
            w = w || wr;
            @(posedge aclk);
            if (a)
                awv <= 1'b0;
            if (w)
                wv <= 1'b0;
        end
        do begin
            guard(n);
            @(negedge aclk);
        end while (bv !== 1'b1);
        chk("bresp", {30'h0, RESP_OKAY}, {30'h0, br});
        @(posedge aclk);
    endtask

    task automatic rd_reg(input logic [7:0] i, input logic [31:0] ed,
                          input logic [1:0] er);
        logic a;
        int   n;
        a = 1'b0;
        n = 0;
        ara <= {2'h0, i, 2'h0};
        arv <= 1'b1;
        while (!a) begin
            guard(n);
            @(negedge aclk);
            a = arr;
            @(posedge aclk);
        end
        arv <= 1'b0;
        do begin
            guard(n);
            @(negedge aclk);
        end while (rv !== 1'b1);
        chk("rdata", ed, rdat);
        chk("rresp", {30'h0, er}, {30'h0, rr});
        @(posedge aclk);
    endtask

    // Alarm must move within the given span of windows
    task automatic wait_al(input int b, input logic l, input int lo, hi);
        int n;
        n = 0;
        while (al[b] !== l && n <= hi * W) begin
            @(negedge aclk);
            n++;
        end
        chk("alarm time", 32'h1, {31'h0, (n > lo * W && n <= hi * W)});
        @(posedge aclk);
    endtask

    task automatic chk_irq(input logic e);
        @(negedge aclk);
        chk("irq_n", {31'h0, e}, {31'h0, irq_n});
        @(posedge aclk);
    endtask

    // Move to the middle of a window
    task automatic mid;
        do @(negedge aclk); while (cyc % W != W / 2);
        @(posedge aclk);
    endtask

    // Switch format mid-window, then time the remote alarm
    task automatic fmt_al(input lad_fmt_type f, input logic l,
                          input int lo, hi);
        mid;
        wr_reg(IDX_FORMAT, {29'h0, f});
        wait_al(BIT_RM, l, lo, hi);
    endtask

    initial begin
        aclk = 1'b0;
        forever #12.5 aclk = ~aclk;
    end

    always @(posedge aclk) cyc <= aresetn ? cyc + 1 : 0;

    initial begin
        {aresetn, awv, wv, arv, mode, awa, ara, wd} = '0;
        {ce, sync_ok, bb, rb, ws} = 8'hFF; // Answers always taken
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        // Reset values, then an unmapped and a read-only place
        for (int i = 0; i < 10; i++)
            rd_reg(IDX_FORMAT + 8'(i), (i == 0) ? {29'h0, FMT_RESET} :
                   (i > 3) ? {24'h0, THR_RESET} : 32'h0, RESP_OKAY);
        rd_reg(8'hC4, 32'h0, RESP_SLVERR);
        wr_reg(IDX_STATE, 32'hFF);
        rd_reg(IDX_STATE, 32'h0, RESP_OKAY);
        // Frame loss with its flag, mask and acknowledge
        wr_reg(IDX_FL_DECL, 32'h2);
        mid;
        sync_ok <= 1'b0;
        wait_al(BIT_FL, 1'b1, 2, 3);
        rd_reg(IDX_IRQ_FLAGS, 32'h1, RESP_OKAY);
        chk_irq(1'b1);
        wr_reg(IDX_IRQ_EN, 32'h1);
        chk_irq(1'b0);
        wr_reg(IDX_IRQ_FLAGS, 32'h0);
        rd_reg(IDX_IRQ_FLAGS, 32'h1, RESP_OKAY);
        wr_reg(IDX_IRQ_FLAGS, 32'h1);
        rd_reg(IDX_IRQ_FLAGS, 32'h0, RESP_OKAY);
        chk_irq(1'b1);
        mid;
        sync_ok <= 1'b1;
        wait_al(BIT_FL, 1'b0, 1, 2);
        chk_irq(1'b0);
        wr_reg(IDX_IRQ_FLAGS, 32'h7);
        // All-ones declare and clear
        wr_reg(IDX_AO_DECL, 32'h2);
        wr_reg(IDX_AO_CLR, 32'h3);
        wr_reg(IDX_IRQ_EN, 32'h4);
        mid;
        mode <= 2'h1;
        wait_al(BIT_AO, 1'b1, 2, 3);
        chk_irq(1'b0);
        mid;
        mode <= 2'h0;
        wait_al(BIT_AO, 1'b0, 2, 3);
        // Remote alarm from data-link patterns
        wr_reg(IDX_RM_CLR, 32'h2);
        mid;
        mode <= 2'h2;
        wait_al(BIT_RM, 1'b1, 1, 2);
        mid;
        mode <= 2'h0;
        wait_al(BIT_RM, 1'b0, 1, 2);
        // Remote verdicts of the other formats, zeros then ones
        fmt_al(FMT_SLC96, 1'b1, 0, 1);
        fmt_al(FMT_J1SF, 1'b0, 1, 2);
        fmt_al(FMT_DM, 1'b1, 0, 1);
        fmt_al(FMT_DL_OTHER, 1'b0, 1, 2);
        mid;
        mode <= 2'h1;
        wait_al(BIT_RM, 1'b1, 1, 2);
        fmt_al(FMT_SLC96, 1'b0, 1, 2);
        fmt_al(FMT_J1SF, 1'b1, 0, 1);
        fmt_al(FMT_SF, 1'b0, 1, 2);
        print_verdict;
    end
endmodule
